//--- hdl/file_res_pkg.sv
`default_nettype none
package file_res_pkg;

   // Register byte addresses on the APB side
   localparam logic [7:0] ADDR_RES_ID   = 8'h00;
   localparam logic [7:0] ADDR_OFFSET   = 8'h04;
   localparam logic [7:0] ADDR_NAME_LO  = 8'h08;
   localparam logic [7:0] ADDR_NAME_HI  = 8'h0c;
   localparam logic [7:0] ADDR_CMD      = 8'h10;
   localparam logic [7:0] ADDR_STATUS   = 8'h14;
   localparam logic [7:0] ADDR_RESP_LO  = 8'h18;
   localparam logic [7:0] ADDR_RESP_HI  = 8'h1c;
   localparam logic [7:0] ADDR_SIZE     = 8'h20;

   // Field positions
   localparam int unsigned RID_W          = 9;
   localparam int unsigned DIR_WR_BIT     = 16;
   localparam int unsigned OFFSET_W       = 15;
   localparam int unsigned CMD_START_BIT  = 0;
   localparam int unsigned ST_BUSY_BIT    = 0;
   localparam int unsigned ST_DONE_BIT    = 1;
   localparam int unsigned ST_ERR_BIT     = 2;
   localparam int unsigned ST_LOADED_BIT  = 3;
   localparam int unsigned ST_CODE_LSB    = 8;
   localparam int unsigned OP_LSB         = 8;
   localparam int unsigned WR_LVL_LSB     = 4;
   localparam int unsigned RD_LVL_LSB     = 0;

   // Resource identifiers
   localparam logic [8:0] RID_FILE_LOAD    = 9'h130;
   localparam logic [8:0] RID_FILE_STATUS  = 9'h132;
   localparam logic [8:0] RID_FILE_MANAGE  = 9'h133;

   // Defining values: data size, read level, write level, time overrun, type
   localparam logic [7:0] LOAD_DEF_SIZE    = 8'h08;
   localparam logic [3:0] LOAD_DEF_RD      = 4'hf;
   localparam logic [3:0] LOAD_DEF_WR      = 4'h1;
   localparam logic [7:0] LOAD_DEF_TOVR    = 8'h82;
   localparam logic [7:0] LOAD_DEF_TYPE    = 8'h0b;
   localparam logic [7:0] STAT_DEF_SIZE    = 8'h04;
   localparam logic [3:0] STAT_DEF_RD      = 4'h0;
   localparam logic [3:0] STAT_DEF_WR      = 4'hf;
   localparam logic [7:0] STAT_DEF_TOVR    = 8'h46;
   localparam logic [7:0] STAT_DEF_TYPE    = 8'h14;
   localparam logic [7:0] MNG_DEF_SIZE     = 8'h08;
   localparam logic [3:0] MNG_DEF_RD       = 4'hf;
   localparam logic [3:0] MNG_DEF_WR       = 4'h0;
   localparam logic [7:0] MNG_DEF_TOVR     = 8'h82;
   localparam logic [7:0] MNG_DEF_TYPE     = 8'h0b;

   // Operation codes in offset bits 9..8
   localparam logic [1:0] OP_DELETE  = 2'h0;
   localparam logic [1:0] OP_CHANGE  = 2'h1;
   localparam logic [1:0] OP_CREATE  = 2'h3;

   // Access levels; 5..14 are reserved, 15 means never
   localparam logic [3:0] LVL_SERVICE  = 4'h4;
   localparam logic [3:0] LVL_NEVER    = 4'hf;

   // Name characters
   localparam logic [7:0] CHR_END     = 8'h00;
   localparam logic [7:0] CHR_FIRST   = 8'h20;
   localparam logic [7:0] CHR_LAST    = 8'h7e;

   // Error codes reported in the status register
   localparam logic [7:0] ERR_NONE        = 8'h00;
   localparam logic [7:0] ERR_BAD_RID     = 8'h01;
   localparam logic [7:0] ERR_NOT_LOADED  = 8'h02;
   localparam logic [7:0] ERR_EXISTS      = 8'h03;
   localparam logic [7:0] ERR_FULL        = 8'h04;
   localparam logic [7:0] ERR_NAME        = 8'h05;
   localparam logic [7:0] ERR_NO_FILE     = 8'h06;
   localparam logic [7:0] ERR_MISMATCH    = 8'h07;
   localparam logic [7:0] ERR_BAD_OP      = 8'h08;
   localparam logic [7:0] ERR_LEVEL       = 8'h09;

   // Interpreter states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } state_e;

endpackage
`default_nettype wire

//--- hdl/file_name_match.sv
`default_nettype none
module file_name_match #(
   parameter int unsigned IDX_W = 3
) (
   // File table
   input  wire logic [(1<<IDX_W)-1:0]       valid,
   input  wire logic [(1<<IDX_W)-1:0][63:0] names,
   // Requested name
   input  wire logic [63:0]                 name,
   // Results
   output logic                             hit,
   output logic [IDX_W-1:0]                 hit_idx,
   output logic                             free,
   output logic [IDX_W-1:0]                 free_idx
);

   // Descending scan so the lowest matching slot wins
   always_comb begin
      hit      = 1'b0;
      hit_idx  = '0;
      free     = 1'b0;
      free_idx = '0;
      for (int i = (1 << IDX_W) - 1; i >= 0; i--) begin
         if (valid[i] && names[i] == name) begin
            hit     = 1'b1;
            hit_idx = IDX_W'(i);
         end
         if (!valid[i]) begin
            free     = 1'b1;
            free_idx = IDX_W'(i);
         end
      end
   end

endmodule // file_name_match
`default_nettype wire

//--- hdl/file_manager.sv
// What this block does
// - Offer a file-status resource, id 132h, four-byte structure type 14h.
// - Read direction of file status returns size 4, levels 0/15, overrun 70.
// - Write direction of file status returns loaded file levels and size.
// - Status bytes: 3/2 size, 1 reserved, 0 holds write and read levels.
// - Levels are 4-bit: 0..4 named, 5..14 reserved, 15 never allowed.
// - Offer manage resource 133h: size 8, read 15, overrun 130, type 0Bh.
// - Refuse loading any name not created before.
// - Creating an existing name aborts with an error.
// - Create offset: opcode 11b in 9..8, write level 7..4, read 3..0.
// - Change offset: opcode 01b, new write and read levels.
`default_nettype none
module file_manager
   import file_res_pkg::*;
#(
   parameter int unsigned IDX_W = 3
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   localparam int unsigned FILE_CNT = 1 << IDX_W;

   // Request registers
   logic [RID_W-1:0]    rid_q,     rid_d;
   logic                dir_wr_q,  dir_wr_d;
   logic [OFFSET_W-1:0] offset_q,  offset_d;
   logic [63:0]         name_q,    name_d;
   // Interpreter state and result
   state_e              state_q,   state_d;
   logic                done_q,    done_d;
   logic [7:0]          err_q,     err_d;
   logic [63:0]         resp_q,    resp_d;
   // File table and loaded file
   logic [FILE_CNT-1:0]       valid_q, valid_d;
   logic [FILE_CNT-1:0][63:0] names_q, names_d;
   logic [FILE_CNT-1:0][15:0] size_q,  size_d;
   logic [FILE_CNT-1:0][3:0]  wr_q,    wr_d;
   logic [FILE_CNT-1:0][3:0]  rd_q,    rd_d;
   logic                      loaded_q, loaded_d;
   logic [IDX_W-1:0]          lidx_q,   lidx_d;
   // Bus registers
   logic [31:0]         prdata_d;
   logic                pready_d;
   logic                pslverr_d;

   logic                setup;
   logic                bus_wr;
   logic                hit;
   logic [IDX_W-1:0]    hit_idx;
   logic                free;
   logic [IDX_W-1:0]    free_idx;
   logic [1:0]          op;
   logic [3:0]          new_wr;
   logic [3:0]          new_rd;

   // Defining values laid out as offsets 1..5 of the resource, byte by byte
   function automatic logic [63:0] def_pack(input logic [7:0] size, input logic [3:0] rd,
                                            input logic [3:0] wr, input logic [7:0] tovr,
                                            input logic [7:0] dtype);
      def_pack = {24'h000000, dtype, tovr, 4'h0, wr, 4'h0, rd, size};
   endfunction

   // Level codes 5..14 are reserved and refused
   function automatic logic lvl_ok(input logic [3:0] lvl);
      lvl_ok = (lvl <= LVL_SERVICE) || (lvl == LVL_NEVER);
   endfunction

   // Printable characters, at least one, then only zero padding
   function automatic logic name_ok(input logic [63:0] nm);
      logic       ok;
      logic       ended;
      logic [7:0] b;
      ok    = (nm[7:0] != CHR_END);
      ended = 1'b0;
      for (int i = 0; i < 8; i++) begin
         b = nm[8*i +: 8];
         if (b == CHR_END) begin
            ended = 1'b1;
         end else if (ended || b < CHR_FIRST || b > CHR_LAST) begin
            ok = 1'b0;
         end
      end
      name_ok = ok;
   endfunction

   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == ADDR_RES_ID) || (a == ADDR_OFFSET) || (a == ADDR_NAME_LO) ||
                    (a == ADDR_NAME_HI) || (a == ADDR_CMD) || (a == ADDR_STATUS) ||
                    (a == ADDR_RESP_LO) || (a == ADDR_RESP_HI) || (a == ADDR_SIZE);
   endfunction

   // Name lookup over the whole table in one cycle
   file_name_match #(
      .IDX_W    (IDX_W)
   ) u_match (
      .valid    (valid_q),
      .names    (names_q),
      .name     (name_q),
      .hit      (hit),
      .hit_idx  (hit_idx),
      .free     (free),
      .free_idx (free_idx)
   );

   // One wait-free access phase: data is captured in setup so prdata is a flop
   assign setup  = psel && !penable;
   assign bus_wr = psel && penable && pready && pwrite && !pslverr;
   assign op     = offset_q[OP_LSB +: 2];
   assign new_wr = offset_q[WR_LVL_LSB +: 4];
   assign new_rd = offset_q[RD_LVL_LSB +: 4];

   // Bus answer, computed at the setup edge
   always_comb begin
      pready_d  = setup;
      pslverr_d = setup && !addr_mapped(paddr);
      prdata_d  = prdata;
      if (setup) begin
         prdata_d = 32'h00000000;
         if (!pwrite) begin
            unique case (paddr)
               ADDR_RES_ID:  prdata_d = {15'h0000, dir_wr_q, 7'h00, rid_q};
               ADDR_OFFSET:  prdata_d = {17'h00000, offset_q};
               ADDR_NAME_LO: prdata_d = name_q[31:0];
               ADDR_NAME_HI: prdata_d = name_q[63:32];
               ADDR_STATUS: begin
                  prdata_d[ST_BUSY_BIT]         = (state_q == ST_EXEC);
                  prdata_d[ST_DONE_BIT]         = done_q;
                  prdata_d[ST_ERR_BIT]          = (err_q != ERR_NONE);
                  prdata_d[ST_LOADED_BIT]       = loaded_q;
                  prdata_d[ST_CODE_LSB +: 8]    = err_q;
               end
               ADDR_RESP_LO: prdata_d = resp_q[31:0];
               ADDR_RESP_HI: prdata_d = resp_q[63:32];
               ADDR_SIZE:    prdata_d = {16'h0000, loaded_q ? size_q[lidx_q] : 16'h0000};
               default:      prdata_d = 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= prdata_d;
         pready  <= pready_d;
         pslverr <= pslverr_d;
      end
   end

   // Request registers, command start and execution of one resource access
   always_comb begin
      rid_d    = rid_q;
      dir_wr_d = dir_wr_q;
      offset_d = offset_q;
      name_d   = name_q;
      state_d  = state_q;
      done_d   = done_q;
      err_d    = err_q;
      resp_d   = resp_q;
      valid_d  = valid_q;
      names_d  = names_q;
      size_d   = size_q;
      wr_d     = wr_q;
      rd_d     = rd_q;
      loaded_d = loaded_q;
      lidx_d   = lidx_q;
      unique case (state_q)
         ST_IDLE: begin
            // Request registers only change while idle, so execution sees a stable request
            if (bus_wr) begin
               if (paddr == ADDR_RES_ID) begin
                  rid_d    = pwdata[RID_W-1:0];
                  dir_wr_d = pwdata[DIR_WR_BIT];
               end
               if (paddr == ADDR_OFFSET) begin
                  offset_d = pwdata[OFFSET_W-1:0];
               end
               if (paddr == ADDR_NAME_LO) begin
                  name_d[31:0] = pwdata;
               end
               if (paddr == ADDR_NAME_HI) begin
                  name_d[63:32] = pwdata;
               end
               if (paddr == ADDR_CMD && pwdata[CMD_START_BIT]) begin
                  state_d = ST_EXEC;
                  done_d  = 1'b0;
                  err_d   = ERR_NONE;
               end
               // The data store outside reports the loaded file's new size here
               if (paddr == ADDR_SIZE && loaded_q) begin
                  size_d[lidx_q] = pwdata[15:0];
               end
            end
         end
         ST_EXEC: begin
            state_d = ST_IDLE;
            done_d  = 1'b1;
            resp_d  = 64'h0000000000000000;
            unique case (rid_q)
               RID_FILE_LOAD: begin
                  if (!dir_wr_q) begin
                     resp_d = def_pack(LOAD_DEF_SIZE, LOAD_DEF_RD, LOAD_DEF_WR,
                                       LOAD_DEF_TOVR, LOAD_DEF_TYPE);
                  end else if (hit) begin
                     loaded_d = 1'b1;
                     lidx_d   = hit_idx;
                  end else begin
                     loaded_d = 1'b0;          // A failed load still drops the old file
                     err_d    = ERR_NO_FILE;
                  end
               end
               RID_FILE_STATUS: begin
                  if (!dir_wr_q) begin
                     resp_d = def_pack(STAT_DEF_SIZE, STAT_DEF_RD, STAT_DEF_WR,
                                       STAT_DEF_TOVR, STAT_DEF_TYPE);
                  end else if (!loaded_q) begin
                     err_d = ERR_NOT_LOADED;
                  end else begin
                     // Offset is ignored: the whole status fits one reply
                     resp_d = {32'h00000000, size_q[lidx_q], 8'h00,
                               wr_q[lidx_q], rd_q[lidx_q]};
                  end
               end
               RID_FILE_MANAGE: begin
                  if (!dir_wr_q) begin
                     resp_d = def_pack(MNG_DEF_SIZE, MNG_DEF_RD, MNG_DEF_WR,
                                       MNG_DEF_TOVR, MNG_DEF_TYPE);
                  end else begin
                     unique case (op)
                        OP_CREATE: begin
                           if (!name_ok(name_q)) begin
                              err_d = ERR_NAME;
                           end else if (hit) begin
                              err_d = ERR_EXISTS;
                           end else if (!lvl_ok(new_wr) || !lvl_ok(new_rd)) begin
                              err_d = ERR_LEVEL;
                           end else if (!free) begin
                              err_d = ERR_FULL;
                           end else begin
                              valid_d[free_idx] = 1'b1;
                              names_d[free_idx] = name_q;
                              size_d[free_idx]  = 16'h0000;
                              wr_d[free_idx]    = new_wr;
                              rd_d[free_idx]    = new_rd;
                           end
                        end
                        OP_CHANGE: begin
                           if (!loaded_q) begin
                              err_d = ERR_NOT_LOADED;
                           end else if (!lvl_ok(new_wr) || !lvl_ok(new_rd)) begin
                              err_d = ERR_LEVEL;
                           end else begin
                              wr_d[lidx_q] = new_wr;
                              rd_d[lidx_q] = new_rd;
                           end
                        end
                        OP_DELETE: begin
                           if (!loaded_q) begin
                              err_d = ERR_NOT_LOADED;
                           end else if (!hit || hit_idx != lidx_q) begin
                              err_d = ERR_MISMATCH;
                           end else begin
                              valid_d[lidx_q] = 1'b0;
                              loaded_d        = 1'b0;
                           end
                        end
                        default: err_d = ERR_BAD_OP;
                     endcase
                  end
               end
               default: err_d = ERR_BAD_RID;
            endcase
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // Table contents are volatile here; a reset empties it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rid_q    <= '0;
         dir_wr_q <= 1'b0;
         offset_q <= '0;
         name_q   <= 64'h0000000000000000;
         state_q  <= ST_IDLE;
         done_q   <= 1'b0;
         err_q    <= ERR_NONE;
         resp_q   <= 64'h0000000000000000;
         valid_q  <= '0;
         names_q  <= '0;
         size_q   <= '0;
         wr_q     <= '0;
         rd_q     <= '0;
         loaded_q <= 1'b0;
         lidx_q   <= '0;
      end else begin
         rid_q    <= rid_d;
         dir_wr_q <= dir_wr_d;
         offset_q <= offset_d;
         name_q   <= name_d;
         state_q  <= state_d;
         done_q   <= done_d;
         err_q    <= err_d;
         resp_q   <= resp_d;
         valid_q  <= valid_d;
         names_q  <= names_d;
         size_q   <= size_d;
         wr_q     <= wr_d;
         rd_q     <= rd_d;
         loaded_q <= loaded_d;
         lidx_q   <= lidx_d;
      end
   end

endmodule // file_manager
`default_nettype wire

//--- bench/file_manager_props.sv
`default_nettype none
module file_manager_props
   import file_res_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   // Setup cycle and address decode seen by the slave
   logic setup;
   logic mapped;
   assign setup  = psel && !penable;
   assign mapped = (paddr <= ADDR_SIZE) && (paddr[1:0] == 2'h0);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Zero wait states: the answer comes in the first access cycle
   a_ready_first: assert property (setup |=> pready)
      else $error("pready missing in access cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_unmapped: assert property (setup && !mapped |=> pslverr)
      else $error("no pslverr on unmapped address");
   a_err_mapped: assert property (setup && mapped |=> !pslverr)
      else $error("pslverr on mapped address");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_zero: assert property (setup && !mapped && !pwrite |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   // Read data only moves at a setup edge, so a slow master still sees it
   a_rdata_hold: assert property (!setup |=> $stable(prdata))
      else $error("prdata moved outside setup edge");
endmodule // file_manager_props

bind file_manager file_manager_props u_props (
   .clk     (clk),
   .reset_n (reset_n),
   .psel    (psel),
   .penable (penable),
   .pwrite  (pwrite),
   .paddr   (paddr),
   .pwdata  (pwdata),
   .prdata  (prdata),
   .pready  (pready),
   .pslverr (pslverr)
);
`default_nettype wire

//--- bench/host_apb.sv
`default_nettype none
module host_apb (
   // Clock
   input wire logic        clk,
   // APB master side
   output logic            psel,
   output logic            penable,
   output logic            pwrite,
   output logic [7:0]      paddr,
   output logic [31:0]     pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   int n_to = 0;

   // Idle bus at time zero
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
   end

   // One transfer; waits for pready with a bound, never assumes latency
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      int i;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Request stands until the rising edge that samples pready high
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 16) n_to++;
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released data must not look valid
      pwdata  <= ~d;
   endtask
endmodule // host_apb
`default_nettype wire

//--- bench/user_file_status_and_management_bench.sv
`default_nettype none
module user_file_status_and_management_bench
   import file_res_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   int          n_mismatch = 0;
   int          n_checks = 0;
   logic [31:0] seed = 32'h1c3d;
   logic [63:0] f1 = 64'h31454c4946;

   always #2.5 clk = ~clk;

   file_manager dut (
      .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   host_apb host (
      .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected write-direction status word: size high, reserved, levels
   function automatic logic [31:0] stat(logic [3:0] w, logic [3:0] r, logic [15:0] s);
      return {s, 8'h00, w, r};
   endfunction

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      logic e;
      host.xfer(w, a, d, r, e);
      if (host.n_to != 0) begin
         n_mismatch++;
         conclude();
      end
   endtask

   // Issue one resource access and check the error code it reports
   task automatic op(input logic [8:0] resource_identifier, input logic wd, input logic [14:0] off,
                     input logic [63:0] nm, input logic [7:0] code);
      logic [31:0] r;
      int i;
      bus(1'b1, ADDR_RES_ID, {15'h0, wd, 7'h0, resource_identifier}, r);
      bus(1'b1, ADDR_OFFSET, {17'h0, off}, r);
      bus(1'b1, ADDR_NAME_LO, nm[31:0], r);
      bus(1'b1, ADDR_NAME_HI, nm[63:32], r);
      bus(1'b1, ADDR_CMD, 32'h1, r);
      for (i = 0; i < 32; i++) begin
         bus(1'b0, ADDR_STATUS, 32'h0, r);
         if (r[1] === 1'b1) break;
      end
      if (i == 32) begin
         n_mismatch++;
         conclude();
      end
      chk({24'h0, r[15:8]}, {24'h0, code});
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask

   initial begin
      logic [31:0] r;
      logic        e;
      logic [63:0] nm;
      logic [3:0]  wl, rl;
      logic [15:0] sz;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rdchk(ADDR_STATUS, 32'h0);
      host.xfer(1'b0, 8'h24, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      // Read direction returns the defining values
      op(9'h132, 1'b0, 15'h0, 64'h0, 8'h00);
      rdchk(ADDR_RESP_LO, {8'd70, 8'd15, 8'd0, 8'd4});
      rdchk(ADDR_RESP_HI, 32'h14);
      op(9'h133, 1'b0, 15'h0, 64'h0, 8'h00);
      rdchk(ADDR_RESP_LO, {8'd130, 8'd0, 8'd15, 8'd8});
      rdchk(ADDR_RESP_HI, 32'h0b);
      // Refusals and create checks; stimulus keeps host-side obligations
      op(9'h130, 1'b1, 15'h0, f1, 8'h06);
      op(9'h133, 1'b1, 15'h0310, f1, 8'h00);
      op(9'h133, 1'b1, 15'h0310, f1, 8'h03);
      op(9'h133, 1'b1, 15'h0300, 64'h0, 8'h05);
      op(9'h133, 1'b1, 15'h0300, 64'h7f41, 8'h05);
      op(9'h133, 1'b1, 15'h0350, 64'h42, 8'h09);
      op(9'h133, 1'b1, 15'h0200, 64'h42, 8'h08);
      op(9'h133, 1'b1, 15'h0100, 64'h0, 8'h02);
      op(9'h130, 1'b1, 15'h0, f1, 8'h00);
      rdchk(ADDR_STATUS, 32'h0a);
      bus(1'b1, ADDR_SIZE, 32'h35, r);
      op(9'h132, 1'b1, 15'h0, 64'h0, 8'h00);
      rdchk(ADDR_RESP_LO, stat(4'h1, 4'h0, 16'h35));
      op(9'h133, 1'b1, 15'h01f2, 64'h0, 8'h00);
      op(9'h132, 1'b1, 15'h0, 64'h0, 8'h00);
      rdchk(ADDR_RESP_LO, stat(4'hf, 4'h2, 16'h35));
      op(9'h133, 1'b1, 15'h0, f1, 8'h00);
      op(9'h130, 1'b1, 15'h0, f1, 8'h06);
      // Random names, levels and sizes through the whole life of a file
      for (int k = 0; k < 6; k++) begin
         nm = {32'h0, (xs() & 32'h0f0f0f0f) | 32'h41414141};
         wl = 4'(xs() % 6);
         rl = 4'(xs() % 6);
         if (wl == 4'h5) wl = 4'hf;
         if (rl == 4'h5) rl = 4'hf;
         sz = 16'(xs());
         op(9'h133, 1'b1, {5'h0, 2'b11, wl, rl}, nm, 8'h00);
         op(9'h130, 1'b1, 15'h0, nm, 8'h00);
         bus(1'b1, ADDR_SIZE, {16'h0, sz}, r);
         op(9'h132, 1'b1, 15'h0, 64'h0, 8'h00);
         rdchk(ADDR_RESP_LO, stat(wl, rl, sz));
         op(9'h133, 1'b1, 15'h0, nm, 8'h00);
      end
      // Unknown resource, status without a file, delete of a name not loaded
      op(9'h131, 1'b0, 15'h0, 64'h0, 8'h01);
      op(9'h132, 1'b1, 15'h0, 64'h0, 8'h02);
      op(9'h133, 1'b1, 15'h0310, f1, 8'h00);
      op(9'h133, 1'b1, 15'h0300, 64'h42, 8'h00);
      op(9'h130, 1'b1, 15'h0, f1, 8'h00);
      op(9'h133, 1'b1, 15'h0, 64'h42, 8'h07);
      op(9'h133, 1'b1, 15'h0, f1, 8'h00);
      // Fill every slot; one more create is refused
      for (int k = 0; k < 7; k++) begin
         op(9'h133, 1'b1, 15'h0300, 64'(8'h30 + k), 8'h00);
      end
      op(9'h133, 1'b1, 15'h0300, 64'h39, 8'h04);
      // Reset in mid-run empties the table
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rdchk(ADDR_STATUS, 32'h0);
      op(9'h130, 1'b1, 15'h0, 64'h42, 8'h06);
      conclude();
   end
endmodule // user_file_status_and_management_bench
`default_nettype wire
